// ### src/pmd_agu.sv
// Effective address generator for one pointer register
`timescale 1ns/10ps
module pmd_agu
   import pmd_pkg::*;
(
   input wire logic [2:0] mode,
   input wire logic [2:0] rsel,
   input wire logic [15:0] ptr,
   input wire logic [15:0] offs,
   input wire logic [15:0] ext,
   output pmd_agu_t res
);
   // Address and post-update; the offset value is only read, never written back
   always_comb
   begin
      res.addr = ptr;
      res.new_ptr = ptr;
      res.upd = 1'b0;
      case (mode)
         3'b000:
         begin
            res.new_ptr = ptr - offs;
            res.upd = 1'b1;
         end
         3'b001:
         begin
            res.new_ptr = ptr + offs;
            res.upd = 1'b1;
         end
         3'b010:
         begin
            res.new_ptr = ptr - 16'h0001;
            res.upd = 1'b1;
         end
         3'b011:
         begin
            res.new_ptr = ptr + 16'h0001;
            res.upd = 1'b1;
         end
         3'b101: res.addr = ptr + offs; // Indexed, pointer untouched
         3'b110:
         begin
            if (rsel == 3'h0)
               res.addr = ext; // Absolute from extension word
            else
            begin
               res.addr = ptr - 16'h0001;
               res.new_ptr = ptr - 16'h0001;
               res.upd = 1'b1;
            end
         end
         default: res.upd = 1'b0; // No update
      endcase
   end
endmodule // pmd_agu

// ### src/pmd_limit.sv
// Saturation limiter for one full accumulator used as a move source
`timescale 1ns/10ps
`include "pmd_map.svh"
module pmd_limit
   import pmd_pkg::*;
(
   input wire logic [7:0] ext,
   input wire logic [23:0] hi,
   input wire logic [23:0] lo,
   output pmd_lim_t res
);
   logic in_use;
   // Extension in use when it differs from the sign of the high word
   assign in_use = !((&{ext, hi[23]}) || !(|{ext, hi[23]}));
   // Clamp toward the sign held in the extension
   always_comb
   begin
      res.limited = in_use;
      res.hi = hi;
      res.lo = lo;
      if (in_use)
      begin
         res.hi = ext[7] ? `PMD_SAT_NEG : `PMD_SAT_POS;
         res.lo = ext[7] ? `PMD_LO_NEG : `PMD_LO_POS;
      end
   end
endmodule // pmd_limit

// ### src/pmd_map.svh
// Register offsets, field positions, reset values and decode constants of the move decoder
`ifndef PMD_MAP_SVH
`define PMD_MAP_SVH
`define PMD_OFS_CCR 8'h00
`define PMD_OFS_MODE 8'h04
`define PMD_OFS_IRQ_STAT 8'h08
`define PMD_OFS_IRQ_MASK 8'h0C
`define PMD_OFS_PTR_BASE 8'h20
`define PMD_OFS_OFF_BASE 8'h40
`define PMD_OFS_DREG_BASE 8'h60
`define PMD_BANK_SPAN 8'h20
`define PMD_DREG_SPAN 8'h28
`define PMD_CCR_RESET 8'h00
`define PMD_MODE_RESET 8'h00
`define PMD_PC_RESET 16'h0000
`define PMD_CCR_LIMIT_BIT 6
`define PMD_IRQ_SAT_BIT 0
`define PMD_IRQ_DONE_BIT 1
`define PMD_LONG_TAG 4'h4
`define PMD_EA_ABS 6'h30
`define PMD_SAT_POS 24'h7FFFFF
`define PMD_SAT_NEG 24'h800000
`define PMD_LO_POS 24'hFFFFFF
`define PMD_LO_NEG 24'h000000
`define PMD_X0 4'h0
`define PMD_X1 4'h1
`define PMD_Y0 4'h2
`define PMD_Y1 4'h3
`define PMD_A0 4'h4
`define PMD_A1 4'h5
`define PMD_A2 4'h6
`define PMD_B0 4'h7
`define PMD_B1 4'h8
`define PMD_B2 4'h9
`endif

// ### src/pmd_move_decoder.sv
// Parallel long and dual data move decoder with AHB-Lite register access
//
// Contract
// - Long ea form: bits 23..20 0100, bit18 0, bit14 1, fields as placed.
// - Long short form: bit14 0, bits 13..8 give a six-bit absolute address.
// - ea low bits pick pointer, upper bits pick mode; 110000 means extension address.
// - Pick code chooses register pair; first half to first memory, same address.
// - Long accumulator loads sign-fill extension; split loads also clear low words.
// - Full accumulator source with extension in use stores saturation constant.
// - Any limiting during a move sets the sticky limit bit, others unchanged.
// - Sticky limit bit stays set until software clears it.
// - Dual move moves one word per memory, each side read or write.
// - Dual addresses come from opposite pointer banks, all parallel modes allowed; the code gives each side four: no update, post +offset, post -1, post +1.
// - Arithmetic opcode sits in bits 7..0 of every move instruction.
// - One register may feed arithmetic and move, or both dual sources.
// - Post-modify by offset writes only the pointer; offset stays unchanged.
//
// The register addresses and the AHB-Lite slave port were chosen for this implementation.
`timescale 1ns/10ps
`include "pmd_map.svh"
module pmd_move_decoder
   import pmd_pkg::*;
(
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic instr_valid,
   input wire logic [23:0] instr_word,
   output logic instr_ready,
   output logic [15:0] pc,
   output logic [7:0] alu_opcode,
   output logic alu_op_valid,
   output pmd_mem_req_t x_mem,
   input wire logic [23:0] x_mem_rdata,
   output pmd_mem_req_t y_mem,
   input wire logic [23:0] y_mem_rdata,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   output logic irq
);
   pmd_core_t s;
   pmd_core_t n;
   logic is_long, is_dual, ldir, lea, xdir, ydir, sat_evt, needs_ext;
   logic [2:0] pick, x_mode, x_rsel, y_rsel;
   logic [5:0] eaf;
   logic [1:0] ee, ff;
   logic [15:0] x_addr;
   logic [23:0] x_src, y_src, rx, ry;
   logic [7:0] wp, wo, wd;
   pmd_agu_t agu_x, agu_y;
   pmd_lim_t lim_a, lim_b;

   // Dual-move mode field to common mode code
   function automatic logic [2:0] dual_mode(input logic [1:0] mm);
      dual_mode = (mm == 2'h0) ? 3'b100 : {1'b0, mm};
   endfunction

   // Full accumulator load: sign into extension, low word cleared
   function automatic pmd_dregs_t fill(input pmd_dregs_t d, input logic [3:0] lo_idx,
                                       input logic [23:0] v);
      fill = d;
      fill[lo_idx] = 24'h000000;
      fill[lo_idx + 4'h1] = v;
      fill[lo_idx + 4'h2] = {16'h0000, {8{v[23]}}};
   endfunction

   // Register read mux, unmapped words read zero
   function automatic logic [31:0] rd_mux(input logic [7:0] a, input pmd_core_t c);
      logic [7:0] p;
      logic [7:0] o;
      logic [7:0] d;
      p = a - `PMD_OFS_PTR_BASE;
      o = a - `PMD_OFS_OFF_BASE;
      d = a - `PMD_OFS_DREG_BASE;
      rd_mux = 32'h00000000;
      if (a == `PMD_OFS_CCR)
         rd_mux = {24'h000000, c.condition_code_byte};
      else if (a == `PMD_OFS_MODE)
         rd_mux = {24'h000000, c.mode};
      else if (a == `PMD_OFS_IRQ_STAT)
         rd_mux = {30'h00000000, c.irq_stat};
      else if (a == `PMD_OFS_IRQ_MASK)
         rd_mux = {30'h00000000, c.irq_mask};
      else if (p < `PMD_BANK_SPAN)
         rd_mux = {16'h0000, c.ptr[p[4:2]]};
      else if (o < `PMD_BANK_SPAN)
         rd_mux = {16'h0000, c.offs[o[4:2]]};
      else if (d < `PMD_DREG_SPAN)
         rd_mux = {8'h00, c.dreg[d[5:2]]};
   endfunction

   assign is_long = (s.word[23:20] == `PMD_LONG_TAG) && !s.word[18];
   assign pick = {s.word[19], s.word[17], s.word[16]};
   assign ldir = s.word[15];
   assign lea = s.word[14];
   assign eaf = s.word[13:8];
   assign is_dual = s.word[23];
   assign ydir = s.word[22];
   assign ee = s.word[19:18];
   assign ff = s.word[17:16];
   assign xdir = s.word[15];
   // mode and pointer from ea field
   assign x_mode = is_long ? eaf[5:3] : dual_mode(s.word[12:11]);
   assign x_rsel = is_long ? eaf[2:0] : s.word[10:8];
   // second address from the opposite bank
   assign y_rsel = {~s.word[10], s.word[14:13]};
   // short absolute address when bit14 clear
   assign x_addr = (is_long && !lea) ? {10'h000, eaf} : agu_x.addr;
   // absolute long ea needs the following word
   assign needs_ext = (instr_word[23:20] == `PMD_LONG_TAG) && !instr_word[18] &&
                      instr_word[14] && (instr_word[13:8] == `PMD_EA_ABS);
   assign rx = x_mem_rdata;
   assign ry = y_mem_rdata;
   assign wp = s.ahb_addr - `PMD_OFS_PTR_BASE;
   assign wo = s.ahb_addr - `PMD_OFS_OFF_BASE;
   assign wd = s.ahb_addr - `PMD_OFS_DREG_BASE;

   pmd_agu u_agu_x (
      .mode(x_mode),
      .rsel(x_rsel),
      .ptr(s.ptr[x_rsel]),
      .offs(s.offs[x_rsel]),
      .ext(s.ext),
      .res(agu_x)
   );
   pmd_agu u_agu_y (
      .mode(dual_mode(s.word[21:20])),
      .rsel(y_rsel),
      .ptr(s.ptr[y_rsel]),
      .offs(s.offs[y_rsel]),
      .ext(s.ext),
      .res(agu_y)
   );
   pmd_limit u_lim_a (
      .ext(s.dreg[`PMD_A2][7:0]),
      .hi(s.dreg[`PMD_A1]),
      .lo(s.dreg[`PMD_A0]),
      .res(lim_a)
   );
   pmd_limit u_lim_b (
      .ext(s.dreg[`PMD_B2][7:0]),
      .hi(s.dreg[`PMD_B1]),
      .lo(s.dreg[`PMD_B0]),
      .res(lim_b)
   );

   // Store data selection; sources may repeat freely
   always_comb
   begin
      x_src = 24'h000000;
      y_src = 24'h000000;
      sat_evt = 1'b0;
      if (is_long)
      begin
         // pair halves to first and second memory
         case (pick)
            3'h0: {x_src, y_src} = {s.dreg[`PMD_A1], s.dreg[`PMD_A0]};
            3'h1: {x_src, y_src} = {s.dreg[`PMD_B1], s.dreg[`PMD_B0]};
            3'h2: {x_src, y_src} = {s.dreg[`PMD_X1], s.dreg[`PMD_X0]};
            3'h3: {x_src, y_src} = {s.dreg[`PMD_Y1], s.dreg[`PMD_Y0]};
            3'h4: {x_src, y_src} = {lim_a.hi, lim_a.lo};
            3'h5: {x_src, y_src} = {lim_b.hi, lim_b.lo};
            3'h6: {x_src, y_src} = {lim_a.hi, lim_b.hi};
            default: {x_src, y_src} = {lim_b.hi, lim_a.hi};
         endcase
         // limiting only for full accumulator codes
         case (pick)
            3'h4: sat_evt = !ldir && lim_a.limited;
            3'h5: sat_evt = !ldir && lim_b.limited;
            3'h6, 3'h7: sat_evt = !ldir && (lim_a.limited || lim_b.limited);
            default: sat_evt = 1'b0;
         endcase
      end
      else if (is_dual)
      begin
         // both sides may name the same source
         case (ee)
            2'h0: x_src = s.dreg[`PMD_X0];
            2'h1: x_src = s.dreg[`PMD_X1];
            2'h2: x_src = lim_a.hi;
            default: x_src = lim_b.hi;
         endcase
         case (ff)
            2'h0: y_src = s.dreg[`PMD_Y0];
            2'h1: y_src = s.dreg[`PMD_Y1];
            2'h2: y_src = lim_a.hi;
            default: y_src = lim_b.hi;
         endcase
         sat_evt = (!xdir && ((ee == 2'h2 && lim_a.limited) || (ee == 2'h3 && lim_b.limited))) ||
                   (!ydir && ((ff == 2'h2 && lim_a.limited) || (ff == 2'h3 && lim_b.limited)));
      end
   end

   // Next state: bus slave, sequencer and register file
   always_comb
   begin
      n = s;
      n.alu_op_valid = 1'b0;
      n.hreadyout = 1'b1; // Zero wait states, so the bus never stalls
      n.hresp = 1'b0;
      n.ahb_wr = hsel && htrans[1] && hready && hwrite;
      n.ahb_addr = haddr[7:0];
      if (hsel && htrans[1] && hready && !hwrite)
         n.hrdata = rd_mux(haddr[7:0], s);
      // Data phase write; hardware updates below take priority
      if (s.ahb_wr)
      begin
         if (s.ahb_addr == `PMD_OFS_CCR)
            n.condition_code_byte = hwdata[7:0];
         else if (s.ahb_addr == `PMD_OFS_MODE)
            n.mode = hwdata[7:0];
         else if (s.ahb_addr == `PMD_OFS_IRQ_STAT)
            n.irq_stat = s.irq_stat & ~hwdata[1:0];
         else if (s.ahb_addr == `PMD_OFS_IRQ_MASK)
            n.irq_mask = hwdata[1:0];
         else if (wp < `PMD_BANK_SPAN)
            n.ptr[wp[4:2]] = hwdata[15:0];
         else if (wo < `PMD_BANK_SPAN)
            n.offs[wo[4:2]] = hwdata[15:0];
         else if (wd < `PMD_DREG_SPAN)
            n.dreg[wd[5:2]] = hwdata[23:0];
      end
      case (s.fsm)
         PMD_IDLE:
         begin
            if (instr_valid)
            begin
               n.word = instr_word;
               n.pc = s.pc + 16'h0001;
               n.fsm = needs_ext ? PMD_EXT : PMD_ACC;
               n.instr_ready = needs_ext;
            end
         end
         PMD_EXT:
         begin
            if (instr_valid)
            begin
               n.ext = instr_word[15:0];
               n.pc = s.pc + 16'h0001;
               n.fsm = PMD_ACC;
               n.instr_ready = 1'b0;
            end
         end
         PMD_ACC:
         begin
            n.alu_op = s.word[7:0];
            n.alu_op_valid = 1'b1;
            n.xreq.addr = x_addr;
            n.yreq.addr = is_long ? x_addr : agu_y.addr;
            n.xreq.wdata = x_src;
            n.yreq.wdata = y_src;
            // one access per memory; long moves share ldir, dual sides use xdir and ydir
            if (is_long)
            begin
               n.xreq.we = !ldir;
               n.xreq.re = ldir;
               n.yreq.we = !ldir;
               n.yreq.re = ldir;
            end
            else if (is_dual)
            begin
               n.xreq.we = !xdir;
               n.xreq.re = xdir;
               n.yreq.we = !ydir;
               n.yreq.re = ydir;
            end
            // only the pointer is written back
            if (((is_long && lea) || is_dual) && agu_x.upd)
               n.ptr[x_rsel] = agu_x.new_ptr;
            if (is_dual && agu_y.upd)
               n.ptr[y_rsel] = agu_y.new_ptr;
            // sticky limit flag, set beats a clear
            if (sat_evt)
            begin
               n.condition_code_byte[`PMD_CCR_LIMIT_BIT] = 1'b1;
               n.irq_stat[`PMD_IRQ_SAT_BIT] = 1'b1;
            end
            n.fsm = PMD_REQ;
         end
         PMD_REQ:
         begin
            n.xreq.we = 1'b0;
            n.xreq.re = 1'b0;
            n.yreq.we = 1'b0;
            n.yreq.re = 1'b0;
            n.fsm = PMD_WB;
         end
         default:
         begin
            // long loads; sign fill and clearing only for full accumulator codes
            if (is_long && ldir)
            begin
               case (pick)
                  3'h0: {n.dreg[`PMD_A1], n.dreg[`PMD_A0]} = {rx, ry};
                  3'h1: {n.dreg[`PMD_B1], n.dreg[`PMD_B0]} = {rx, ry};
                  3'h2: {n.dreg[`PMD_X1], n.dreg[`PMD_X0]} = {rx, ry};
                  3'h3: {n.dreg[`PMD_Y1], n.dreg[`PMD_Y0]} = {rx, ry};
                  3'h4:
                  begin
                     n.dreg = fill(n.dreg, `PMD_A0, rx);
                     n.dreg[`PMD_A0] = ry;
                  end
                  3'h5:
                  begin
                     n.dreg = fill(n.dreg, `PMD_B0, rx);
                     n.dreg[`PMD_B0] = ry;
                  end
                  3'h6:
                  begin
                     n.dreg = fill(n.dreg, `PMD_A0, rx);
                     n.dreg = fill(n.dreg, `PMD_B0, ry);
                  end
                  default:
                  begin
                     n.dreg = fill(n.dreg, `PMD_B0, rx);
                     n.dreg = fill(n.dreg, `PMD_A0, ry);
                  end
               endcase
            end
            // distinct dual destinations assumed; second side written last
            if (is_dual && xdir)
            begin
               case (ee)
                  2'h0: n.dreg[`PMD_X0] = rx;
                  2'h1: n.dreg[`PMD_X1] = rx;
                  2'h2: n.dreg = fill(n.dreg, `PMD_A0, rx);
                  default: n.dreg = fill(n.dreg, `PMD_B0, rx);
               endcase
            end
            if (is_dual && ydir)
            begin
               case (ff)
                  2'h0: n.dreg[`PMD_Y0] = ry;
                  2'h1: n.dreg[`PMD_Y1] = ry;
                  2'h2: n.dreg = fill(n.dreg, `PMD_A0, ry);
                  default: n.dreg = fill(n.dreg, `PMD_B0, ry);
               endcase
            end
            n.irq_stat[`PMD_IRQ_DONE_BIT] = 1'b1;
            n.instr_ready = 1'b1;
            n.fsm = PMD_IDLE;
         end
      endcase
      n.irq = |(n.irq_stat & n.irq_mask);
   end

   // State register
   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         s <= '0;
         s.fsm <= PMD_IDLE;
         s.instr_ready <= 1'b1;
         s.hreadyout <= 1'b1;
         s.pc <= `PMD_PC_RESET;
         s.condition_code_byte <= `PMD_CCR_RESET;
         s.mode <= `PMD_MODE_RESET;
      end
      else
         s <= n;
   end

   assign instr_ready = s.instr_ready;
   assign pc = s.pc;
   assign alu_opcode = s.alu_op;
   assign alu_op_valid = s.alu_op_valid;
   assign x_mem = s.xreq;
   assign y_mem = s.yreq;
   assign hreadyout = s.hreadyout;
   assign hrdata = s.hrdata;
   assign hresp = s.hresp;
   assign irq = s.irq;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!reset_n);

   sequence seq_take_ext;
      s.fsm == PMD_IDLE && instr_valid && needs_ext ##1 s.fsm == PMD_EXT && instr_valid;
   endsequence
   sequence seq_two_words;
      s.fsm == PMD_ACC && s.pc == $past(s.pc, 2) + 16'h0002;
   endsequence

   chk_ext_fetch: assert property (seq_take_ext |=> seq_two_words)
      else $error("extension word not fetched past the counter");
   chk_alu_opcode: assert property (s.fsm == PMD_ACC |=>
      alu_op_valid && alu_opcode == $past(s.word[7:0]))
      else $error("arithmetic opcode not forwarded");
   chk_sat_sets: assert property (s.fsm == PMD_ACC && sat_evt |=>
      s.condition_code_byte[`PMD_CCR_LIMIT_BIT] && s.irq_stat[`PMD_IRQ_SAT_BIT])
      else $error("limit flag not set");
   chk_sat_sticky: assert property (s.condition_code_byte[`PMD_CCR_LIMIT_BIT] &&
      !(s.ahb_wr && s.ahb_addr == `PMD_OFS_CCR) |=> s.condition_code_byte[`PMD_CCR_LIMIT_BIT])
      else $error("limit flag dropped without software");
   chk_offset_const: assert property (s.fsm == PMD_ACC && !s.ahb_wr |=>
      s.offs == $past(s.offs))
      else $error("offset register changed by move");
   chk_long_shared: assert property (s.fsm == PMD_REQ && is_long |->
      x_mem.addr == y_mem.addr && x_mem.we == y_mem.we)
      else $error("long move halves differ in address");
   chk_limit_value: assert property (s.fsm == PMD_ACC && is_long && !ldir &&
      pick == 3'h4 && lim_a.limited |=> x_mem.we && (x_mem.wdata == `PMD_SAT_POS ||
      x_mem.wdata == `PMD_SAT_NEG))
      else $error("saturation constant not stored");
   chk_sign_fill: assert property (s.fsm == PMD_WB && is_long && ldir && pick == 3'h6 |=>
      s.dreg[`PMD_A2][7:0] == {8{s.dreg[`PMD_A1][23]}} && s.dreg[`PMD_B0] == 24'h000000)
      else $error("split load not sign filled");
   chk_dual_both: assert property (s.fsm == PMD_ACC && is_dual |=>
      (x_mem.we ^ x_mem.re) && (y_mem.we ^ y_mem.re) ##1 !x_mem.we && !y_mem.we)
      else $error("dual move missing one access");
   chk_dual_banks: assert property (s.fsm == PMD_ACC && is_dual |->
      x_rsel[2] != y_rsel[2] ##1
      y_mem.addr == $past(s.ptr[{~s.word[10], s.word[14:13]}]))
      else $error("dual pointers share a bank");
   chk_ea_incr: assert property (s.fsm == PMD_ACC && is_long && lea && eaf[5:3] == 3'b011 &&
      !s.ahb_wr |=> s.ptr[eaf[2:0]] == $past(s.ptr[eaf[2:0]]) + 16'h0001)
      else $error("post increment not applied");
endmodule // pmd_move_decoder

// ### src/pmd_pkg.sv
// Types shared by the parallel long and dual move decoder
package pmd_pkg;
   typedef enum logic [4:0] {
      PMD_IDLE = 5'b00001,
      PMD_EXT = 5'b00010,
      PMD_ACC = 5'b00100,
      PMD_REQ = 5'b01000,
      PMD_WB = 5'b10000
   } pmd_fsm_t;
   typedef struct packed {
      logic [15:0] addr;
      logic [23:0] wdata;
      logic we;
      logic re;
   } pmd_mem_req_t;
   typedef struct packed {
      logic [15:0] addr;
      logic [15:0] new_ptr;
      logic upd;
   } pmd_agu_t;
   typedef struct packed {
      logic [23:0] hi;
      logic [23:0] lo;
      logic limited;
   } pmd_lim_t;
   typedef logic [9:0][23:0] pmd_dregs_t;
   typedef struct packed {
      pmd_fsm_t fsm;
      logic [23:0] word;
      logic [15:0] ext;
      logic [15:0] pc;
      logic instr_ready;
      logic [7:0][15:0] ptr;
      logic [7:0][15:0] offs;
      pmd_dregs_t dreg;
      logic [7:0] condition_code_byte;
      logic [7:0] mode;
      logic [1:0] irq_stat;
      logic [1:0] irq_mask;
      logic irq;
      pmd_mem_req_t xreq;
      pmd_mem_req_t yreq;
      logic [7:0] alu_op;
      logic alu_op_valid;
      logic ahb_wr;
      logic [7:0] ahb_addr;
      logic [31:0] hrdata;
      logic hreadyout;
      logic hresp;
   } pmd_core_t;
endpackage

// ### verif/pmd_mem_model.sv
// Synchronous data memory model standing in for one on-chip memory
`timescale 1ns/10ps
module pmd_mem_model
   import pmd_pkg::*;
(
   input wire logic sys_clk,
   input pmd_mem_req_t req,
   output logic [23:0] rdata
);
   logic [23:0] mem [0:255];
   // Start clean so stores can be told apart from stale data
   initial
   begin
      rdata = 24'h000000;
      for (int k = 0; k < 256; k++)
         mem[k] = 24'h000000;
   end
   // Read data valid only the cycle after re; otherwise it toggles, never holds
   always @(posedge sys_clk)
   begin
      if (req.we)
         mem[req.addr[7:0]] <= req.wdata;
      rdata <= req.re ? mem[req.addr[7:0]] : ~rdata;
   end
endmodule // pmd_mem_model

// ### verif/test_parallel_long_and_dual_move_decode.sv
// Self-checking bench for the parallel long and dual move decoder
`timescale 1ns/10ps
module test_parallel_long_and_dual_move_decode
   import pmd_pkg::*;
;
   logic sys_clk, reset_n, instr_valid, instr_ready, alu_op_valid;
   logic hsel, hwrite, hreadyout, hresp, irq;
   logic [23:0] instr_word, x_rd, y_rd;
   logic [15:0] pc, p;
   logic [7:0] alu_opcode;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans;
   logic [2:0] hsize;
   pmd_mem_req_t x_mem, y_mem;
   int n_errors, check_count;
   pmd_move_decoder DUT (.sys_clk(sys_clk), .reset_n(reset_n), .instr_valid(instr_valid),
      .instr_word(instr_word), .instr_ready(instr_ready), .pc(pc), .alu_opcode(alu_opcode),
      .alu_op_valid(alu_op_valid), .x_mem(x_mem), .x_mem_rdata(x_rd), .y_mem(y_mem),
      .y_mem_rdata(y_rd), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hrdata(hrdata), .hresp(hresp), .irq(irq));
   pmd_mem_model x_m (.sys_clk(sys_clk), .req(x_mem), .rdata(x_rd));
   pmd_mem_model y_m (.sys_clk(sys_clk), .req(y_mem), .rdata(y_rd));
   // 40 MHz core clock
   initial
   begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end
   task test_done();
      $display("checks %0d mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp)
      begin
         n_errors++;
         $display("FAIL %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // Bounded wait on one handshake output (0 bus, 1 instr, 2 opcode); a hang is a mismatch
   task automatic wait_hi(input int sel);
      logic v;
      for (int k = 0; k < 20; k++)
      begin
         @(posedge sys_clk);
         v = (sel == 0) ? hreadyout : ((sel == 1) ? instr_ready : alu_op_valid);
         if (v === 1'b1)
            return;
      end
      n_errors++;
      $display("FAIL handshake expected 1 seen timeout");
      test_done();
   endtask
   // One single-word AHB transfer; read data lands in rd
   task ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge sys_clk);
      hsel <= 1'b1;
      haddr <= {24'h000000, a};
      htrans <= 2'b10;
      hwrite <= wr;
      wait_hi(0);
      htrans <= 2'b00;
      hwdata <= wd;
      wait_hi(0);
      rd = hrdata;
   endtask
   task rd_chk(input string nm, input logic [7:0] a, input logic [31:0] exp);
      ahb(1'b0, a, 32'h00000000);
      chk(nm, exp, rd);
      chk("hresp", 32'h00000000, {31'h0, hresp});
   endtask
   task instr(input logic [23:0] w, input logic ext, input logic [23:0] ew);
      instr_word <= w;
      instr_valid <= 1'b1;
      wait_hi(1);
      if (ext)
      begin
         instr_word <= ew;
         wait_hi(1);
      end
      instr_valid <= 1'b0;
      wait_hi(2);
      chk("alu_opcode", {24'h0, w[7:0]}, {24'h0, alu_opcode});
      wait_hi(1);
   endtask
   task t_regs();
      rd_chk("ccr", 8'h00, 32'h00000000);
      rd_chk("mode", 8'h04, 32'h00000000);
      ahb(1'b1, 8'h04, 32'h000000A5);
      rd_chk("mode", 8'h04, 32'h000000A5);
      rd_chk("unmapped", 8'hFC, 32'h00000000);
      $display("test regs done");
   endtask
   task t_long_store();
      ahb(1'b1, 8'h24, 32'h00000010);
      ahb(1'b1, 8'h74, 32'h00123456);
      ahb(1'b1, 8'h70, 32'h00654321);
      instr(24'h405911, 1'b0, 24'h000000);
      chk("x_mem", 32'h00123456, {8'h0, x_m.mem[8'h10]});
      chk("y_mem", 32'h00654321, {8'h0, y_m.mem[8'h10]});
      rd_chk("ptr1", 8'h24, 32'h00000011);
      $display("test long store done");
   endtask
   task t_long_load_ext();
      x_m.mem[8'h05] = 24'h800001;
      y_m.mem[8'h05] = 24'h000002;
      p = pc;
      instr(24'h48F022, 1'b1, 24'h000005);
      chk("pc", {16'h0, p + 16'h0002}, {16'h0, pc});
      rd_chk("acc_ext", 8'h78, 32'h000000FF);
      rd_chk("acc_hi", 8'h74, 32'h00800001);
      rd_chk("acc_lo", 8'h70, 32'h00000002);
      instr(24'h4A8566, 1'b0, 24'h000000);
      rd_chk("split_a_lo", 8'h70, 32'h00000000);
      rd_chk("split_b_hi", 8'h80, 32'h00000002);
      rd_chk("split_b_ext", 8'h84, 32'h00000000);
      $display("test long load done");
   endtask
   task t_saturate();
      ahb(1'b1, 8'h78, 32'h00000001);
      instr(24'h480733, 1'b0, 24'h000000);
      chk("x_sat", 32'h007FFFFF, {8'h0, x_m.mem[8'h07]});
      chk("y_sat", 32'h00FFFFFF, {8'h0, y_m.mem[8'h07]});
      rd_chk("ccr", 8'h00, 32'h00000040);
      chk("irq_masked", 32'h0, {31'h0, irq});
      rd_chk("irq_stat", 8'h08, 32'h00000003);
      ahb(1'b1, 8'h0C, 32'h00000001);
      repeat (2) @(posedge sys_clk);
      chk("irq_on", 32'h1, {31'h0, irq});
      ahb(1'b1, 8'h08, 32'h00000003);
      repeat (2) @(posedge sys_clk);
      chk("irq_off", 32'h0, {31'h0, irq});
      rd_chk("ccr", 8'h00, 32'h00000040);
      $display("test saturate done");
   endtask
   task t_dual();
      ahb(1'b1, 8'h20, 32'h00000030);
      ahb(1'b1, 8'h30, 32'h00000040);
      ahb(1'b1, 8'h40, 32'h00000005);
      ahb(1'b1, 8'h50, 32'h00000023);
      ahb(1'b1, 8'h60, 32'h00123123);
      ahb(1'b1, 8'h68, 32'h00456456);
      instr(24'h90085A, 1'b0, 24'h000000);
      chk("x_dual", 32'h00123123, {8'h0, x_m.mem[8'h30]});
      chk("y_dual", 32'h00456456, {8'h0, y_m.mem[8'h40]});
      rd_chk("ptr0", 8'h20, 32'h00000035);
      rd_chk("ptr4", 8'h30, 32'h00000063);
      rd_chk("off4", 8'h50, 32'h00000023);
      $display("test dual done");
   endtask
   // Reset, then the scenarios in order
   initial
   begin
      n_errors = 0;
      check_count = 0;
      reset_n = 1'b0;
      instr_valid = 1'b0;
      instr_word = 24'h000000;
      hsel = 1'b0;
      haddr = 32'h00000000;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'b010;
      hwdata = 32'h00000000;
      repeat (5) @(posedge sys_clk);
      reset_n <= 1'b1;
      t_regs();
      t_long_store();
      t_long_load_ext();
      t_saturate();
      t_dual();
      test_done();
   end
endmodule // test_parallel_long_and_dual_move_decode
